// ===== common/flash_ops_pkg.sv
// Purpose: Shared constants for the page operation and status core
// Assumes: Core clock of 10 MHz; serial pins sampled by that clock
// Notes:   Times are in microseconds; cycle counts derive from them
package flash_ops_pkg;

  // Core clock rate
  localparam int unsigned CLK_MHZ = 10;

  // Operation times, longest figures in microseconds
  localparam int unsigned COPY_TIME_US    = 200;
  localparam int unsigned COMPARE_TIME_US = 200;
  localparam int unsigned REWRITE_TIME_US = 50000;

  // Longest times round down to whole cycles, never below one
  localparam int unsigned COPY_CYCLES =
    (COPY_TIME_US * CLK_MHZ) > 0 ? COPY_TIME_US * CLK_MHZ : 1;
  localparam int unsigned COMPARE_CYCLES =
    (COMPARE_TIME_US * CLK_MHZ) > 0 ? COMPARE_TIME_US * CLK_MHZ : 1;
  localparam int unsigned REWRITE_CYCLES =
    (REWRITE_TIME_US * CLK_MHZ) > 0 ? REWRITE_TIME_US * CLK_MHZ : 1;

  // Opcodes
  localparam logic [7:0] OPC_COPY_ONE  = 8'h53;
  localparam logic [7:0] OPC_COPY_TWO  = 8'h55;
  localparam logic [7:0] OPC_CMP_ONE   = 8'h60;
  localparam logic [7:0] OPC_CMP_TWO   = 8'h61;
  localparam logic [7:0] OPC_RW_ONE    = 8'h58;
  localparam logic [7:0] OPC_RW_TWO    = 8'h59;
  localparam logic [7:0] OPC_STATUS    = 8'hd7;

  // Command frame length in bits
  localparam logic [5:0] CMD_BITS      = 6'h20;
  localparam logic [5:0] OPC_LAST_BIT  = 6'h07;

  // Page index position inside the 24-bit address
  localparam int unsigned PAGE_LSB_528 = 10;
  localparam int unsigned PAGE_LSB_512 = 9;
  localparam int unsigned PAGE_W       = 12;

  // Status field positions
  localparam int unsigned ST_READY_BIT = 7;
  localparam int unsigned ST_CMP_BIT   = 6;

  // Size code, arbitrary neutral value
  localparam logic [3:0] SIZE_CODE_DEFAULT = 4'h5;

  // Reset values
  localparam logic       CMP_RESET   = 1'b0;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  // Array operation kinds
  typedef enum logic [1:0] {
    OPK_COPY    = 2'h0,
    OPK_COMPARE = 2'h1,
    OPK_PROGRAM = 2'h2
  } op_kind_t;

endpackage : flash_ops_pkg

// ===== core/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter and edge pulses
// Assumes: Input is asynchronous to i_clk
// Notes:   Level changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Raw pin
  input  wire logic i_pin,
  // Filtered level and its edges
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Stage chain; first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= RST_VAL;
      o_rise  <= 1'b0;
      o_fall  <= 1'b0;
    end else begin
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      if (s2_q == s3_q && s3_q != o_level) begin
        o_level <= s3_q;
        o_rise  <= s3_q;
        o_fall  <= ~s3_q;
      end
    end
  end

endmodule : pin_sync

`default_nettype wire

// ===== core/page_ops_core.sv
// Purpose: Serial command core for page copy, compare, rewrite, status read
// Assumes: Serial pins oversampled by i_clk; serial clock at most clk/8
// Notes:   Array data path lives outside; this core times and requests
`timescale 1ns/100ps
`default_nettype none

module page_ops_core #(
  parameter int unsigned CNT_W          = 20,
  parameter int unsigned COPY_CYCLES    = flash_ops_pkg::COPY_CYCLES,
  parameter int unsigned COMPARE_CYCLES = flash_ops_pkg::COMPARE_CYCLES,
  parameter int unsigned REWRITE_CYCLES = flash_ops_pkg::REWRITE_CYCLES,
  parameter logic [3:0]  SIZE_CODE      = flash_ops_pkg::SIZE_CODE_DEFAULT
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Serial pins
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic        i_si,
  output logic             o_so,
  output logic             o_so_oe,
  // Device state shown in the status bytes
  input  wire logic        i_ext_busy,
  input  wire logic        i_protect_on,
  input  wire logic        i_page_512,
  input  wire logic        i_program_erase_fault,
  input  wire logic        i_lockdown_allowed_flag,
  input  wire logic        i_buf_two_program_paused,
  input  wire logic        i_buf_one_program_paused,
  input  wire logic        i_erase_paused_flag,
  // Array operation requests and result
  input  wire logic        i_cmp_mismatch,
  output logic             o_op_start,
  output logic [1:0]       o_op_kind,
  output logic             o_op_buf,
  output logic [11:0]      o_page_index_bits,
  output logic             o_ready
);

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_COPY,
    CMD_COMPARE,
    CMD_REWRITE
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COPY,
    ST_COMPARE,
    ST_RW_COPY,
    ST_RW_PROG
  } state_t;

  localparam logic [CNT_W-1:0] COPY_LOAD =
    CNT_W'(COPY_CYCLES - 1);
  localparam logic [CNT_W-1:0] CMP_LOAD =
    CNT_W'(COMPARE_CYCLES - 1);
  localparam int unsigned PROG_CYCLES =
    REWRITE_CYCLES > COPY_CYCLES ? REWRITE_CYCLES - COPY_CYCLES : 1;
  localparam logic [CNT_W-1:0] PROG_LOAD =
    CNT_W'(PROG_CYCLES - 1);

  logic              cs_n_lvl;
  logic              cs_rise;
  logic              cs_fall;
  logic              sck_rise;
  logic              si_lvl;
  logic [31:0]       frame_q;
  logic [5:0]        bit_cnt_q;
  logic              stream_q;
  logic [3:0]        out_idx_q;
  logic [7:0]        out_byte_q;
  state_t            state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              cmp_q;
  logic              buf_q;
  cmd_t              cmd;
  logic [11:0]       page_sel;
  logic              frame_ok;
  logic              buf_blocked;

  // Opcode to command class
  function automatic cmd_t decode_cmd(input logic [7:0] opc);
    unique case (opc)
      flash_ops_pkg::OPC_COPY_ONE,
      flash_ops_pkg::OPC_COPY_TWO: decode_cmd = CMD_COPY;
      flash_ops_pkg::OPC_CMP_ONE,
      flash_ops_pkg::OPC_CMP_TWO:  decode_cmd = CMD_COMPARE;
      flash_ops_pkg::OPC_RW_ONE,
      flash_ops_pkg::OPC_RW_TWO:   decode_cmd = CMD_REWRITE;
      default:                     decode_cmd = CMD_NONE;
    endcase
  endfunction : decode_cmd

  // Opcode to buffer number, 1 means buffer two
  function automatic logic decode_buf(input logic [7:0] opc);
    decode_buf = (opc == flash_ops_pkg::OPC_COPY_TWO) ||
                 (opc == flash_ops_pkg::OPC_CMP_TWO)  ||
                 (opc == flash_ops_pkg::OPC_RW_TWO);
  endfunction : decode_buf

  // Status byte builder, fresh contents on every call
  function automatic logic [7:0] status_byte(input logic second);
    logic rdy;
    rdy = o_ready;
    if (!second) begin
      status_byte = {rdy, cmp_q, SIZE_CODE,
                     i_protect_on, i_page_512};
    end else begin
      status_byte = {rdy, 1'b0,
                     i_program_erase_fault,
                     1'b0,
                     i_lockdown_allowed_flag,
                     i_buf_two_program_paused,
                     i_buf_one_program_paused,
                     i_erase_paused_flag};
    end
  endfunction : status_byte

  // Pin synchronisers
  pin_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   (i_cs_n),
    .o_level (cs_n_lvl),
    .o_rise  (cs_rise),
    .o_fall  (cs_fall)
  );

  pin_sync #(.RST_VAL(1'b0)) u_sck_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   (i_sck),
    .o_level (),
    .o_rise  (sck_rise),
    .o_fall  ()
  );

  pin_sync #(.RST_VAL(1'b0)) u_si_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   (i_si),
    .o_level (si_lvl),
    .o_rise  (),
    .o_fall  ()
  );

  // Command fields taken from the captured frame
  always_comb begin
    cmd = decode_cmd(frame_q[31:24]);
    if (i_page_512) begin
      page_sel = frame_q[flash_ops_pkg::PAGE_LSB_512 +: 12];
    end else begin
      page_sel = frame_q[flash_ops_pkg::PAGE_LSB_528 +: 12];
    end
    // Whole opcode and three address bytes seen while selected
    frame_ok = (bit_cnt_q == flash_ops_pkg::CMD_BITS);
    // A paused program owns its buffer; writes into it are dropped
    buf_blocked = decode_buf(frame_q[31:24]) ? i_buf_two_program_paused
                                             : i_buf_one_program_paused;
  end

  // Input shift register and bit counter, cleared at frame start
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frame_q   <= 32'h0000_0000;
      bit_cnt_q <= 6'h00;
    end else if (cs_fall) begin
      frame_q   <= 32'h0000_0000;
      bit_cnt_q <= 6'h00;
    end else if (sck_rise && !cs_n_lvl &&
                 bit_cnt_q != flash_ops_pkg::CMD_BITS) begin
      frame_q   <= {frame_q[30:0], si_lvl};
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // Status stream: starts after the opcode, one bit per serial clock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stream_q   <= 1'b0;
      out_idx_q  <= 4'h0;
      out_byte_q <= flash_ops_pkg::SHIFT_RESET;
      o_so       <= 1'b0;
      o_so_oe    <= 1'b0;
    end else if (cs_rise || cs_fall) begin
      stream_q   <= 1'b0;
      out_idx_q  <= 4'h0;
      o_so       <= 1'b0;
      o_so_oe    <= 1'b0;
    end else if (sck_rise && !cs_n_lvl) begin
      if (!stream_q && bit_cnt_q == flash_ops_pkg::OPC_LAST_BIT &&
          {frame_q[6:0], si_lvl} == flash_ops_pkg::OPC_STATUS) begin
        // Accepted whatever the busy state
        stream_q   <= 1'b1;
        o_so_oe    <= 1'b1;
        out_byte_q <= status_byte(1'b0);
        o_so       <= status_byte(1'b0)[7];
        out_idx_q  <= 4'h1;
      end else if (stream_q) begin
        if (out_idx_q[2:0] == 3'h0) begin
          // Fresh byte each time a byte boundary is crossed
          out_byte_q <= status_byte(out_idx_q[3]);
          o_so       <= status_byte(out_idx_q[3])[7];
        end else begin
          o_so       <= out_byte_q[3'h7 - out_idx_q[2:0]];
        end
        out_idx_q <= out_idx_q + 4'h1;
      end
    end
  end

  // Operation sequencer, launched on the rising edge of chip select
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      buf_q   <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // Ignored unless idle and no other internal work
          if (cs_rise && frame_ok && !i_ext_busy) begin
            buf_q <= decode_buf(frame_q[31:24]);
            unique case (cmd)
              CMD_COPY: begin
                if (!buf_blocked) begin
                  state_q <= ST_COPY;
                  cnt_q   <= COPY_LOAD;
                end
              end
              CMD_COMPARE: begin
                state_q <= ST_COMPARE;
                cnt_q   <= CMP_LOAD;
              end
              CMD_REWRITE: begin
                if (!buf_blocked) begin
                  state_q <= ST_RW_COPY;
                  cnt_q   <= COPY_LOAD;
                end
              end
              CMD_NONE: begin
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_COPY, ST_COMPARE, ST_RW_PROG: begin
          if (cnt_q == '0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_RW_COPY: begin
          if (cnt_q == '0) begin
            // Program the buffer back into the same page
            state_q <= ST_RW_PROG;
            cnt_q   <= PROG_LOAD;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  // Request strobe to the array, one per phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_op_start        <= 1'b0;
      o_op_kind         <= flash_ops_pkg::OPK_COPY;
      o_op_buf          <= 1'b0;
      o_page_index_bits <= 12'h000;
    end else begin
      o_op_start <= 1'b0;
      if (state_q == ST_IDLE && cs_rise && frame_ok && !i_ext_busy &&
          cmd != CMD_NONE && !(cmd != CMD_COMPARE && buf_blocked)) begin
        o_op_start        <= 1'b1;
        o_op_buf          <= decode_buf(frame_q[31:24]);
        o_page_index_bits <= page_sel;
        o_op_kind         <= (cmd == CMD_COMPARE) ? flash_ops_pkg::OPK_COMPARE
                                                  : flash_ops_pkg::OPK_COPY;
      end else if (state_q == ST_RW_COPY && cnt_q == '0) begin
        o_op_start <= 1'b1;
        o_op_kind  <= flash_ops_pkg::OPK_PROGRAM;
        o_op_buf   <= buf_q;
      end
    end
  end

  // Compare result captured as the compare finishes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmp_q <= flash_ops_pkg::CMP_RESET;
    end else if (state_q == ST_COMPARE && cnt_q == '0) begin
      cmp_q <= i_cmp_mismatch;
    end
  end

  // Ready flag: low through any internal operation
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ready <= 1'b1;
    end else begin
      o_ready <= (state_q == ST_IDLE) && !i_ext_busy;
    end
  end

endmodule : page_ops_core

`default_nettype wire

// ===== sim/page_ops_core_checker.sv
// Purpose: Port-level assertions for page_ops_core
// Assumes: One clock domain, synchronous reset
// Notes:   Busy windows allow a few cycles of pin sync lag
`timescale 1ns/100ps
`default_nettype none
module page_ops_core_checker #(
  parameter int unsigned COPY_CYCLES    = 20,
  parameter int unsigned COMPARE_CYCLES = 20,
  parameter int unsigned REWRITE_CYCLES = 50
) (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // Watched ports
  input wire logic        i_cs_n,
  input wire logic        i_ext_busy,
  input wire logic        o_so_oe,
  input wire logic        o_op_start,
  input wire logic [1:0]  o_op_kind,
  input wire logic        o_op_buf,
  input wire logic [11:0] o_page_index_bits,
  input wire logic        o_ready
);
  localparam int unsigned CP_HI = COPY_CYCLES + 3;
  localparam int unsigned CM_HI = COMPARE_CYCLES + 3;
  localparam int unsigned RW_HI = REWRITE_CYCLES + 3;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic        live_q;
  logic [1:0]  kind_q;
  logic [19:0] cnt_q;
  // Track the running operation, its last kind and its age
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      live_q <= 1'b0;
      kind_q <= 2'h0;
      cnt_q  <= 20'h0;
    end else begin
      if (o_op_start) begin
        live_q <= 1'b1;
        kind_q <= o_op_kind;
      end else if (o_ready) begin
        live_q <= 1'b0;
      end
      if (o_op_start && !live_q) begin
        cnt_q <= 20'h1;
      end else if (live_q) begin
        cnt_q <= cnt_q + 20'h1;
      end
    end
  end
  start_pulse_a: assert property (o_op_start |=> !o_op_start)
    else $error("start pulse longer than one cycle");
  busy_start_a: assert property (o_op_start |=> !o_ready)
    else $error("ready not low after start");
  copy_time_a: assert property (
    $rose(o_ready) && live_q && kind_q == 2'h0 |-> cnt_q inside {[COPY_CYCLES:CP_HI]})
    else $error("copy busy time out of window");
  cmp_time_a: assert property (
    $rose(o_ready) && live_q && kind_q == 2'h1 |-> cnt_q inside {[COMPARE_CYCLES:CM_HI]})
    else $error("compare busy time out of window");
  rewrite_time_a: assert property (
    $rose(o_ready) && live_q && kind_q == 2'h2 |-> cnt_q inside {[REWRITE_CYCLES:RW_HI]})
    else $error("rewrite busy time out of window");
  rewrite_pair_a: assert property (
    o_op_start && o_op_kind == 2'h2 |-> live_q && kind_q == 2'h0
      && $stable(o_op_buf) && $stable(o_page_index_bits))
    else $error("program phase without matching copy phase");
  ext_busy_a: assert property (i_ext_busy [*2] |-> !o_ready)
    else $error("ready high while busy");
  start_idle_a: assert property (
    o_op_start && !live_q |-> $past(o_ready) && !$past(i_ext_busy))
    else $error("operation started while busy");
  so_release_a: assert property (i_cs_n [*8] |-> !o_so_oe)
    else $error("output still driven after deselect");
  so_start_a: assert property ($rose(o_so_oe) |-> !$past(i_cs_n, 4))
    else $error("output enabled without selection");
endmodule : page_ops_core_checker
bind page_ops_core page_ops_core_checker #(
  .COPY_CYCLES    (COPY_CYCLES),
  .COMPARE_CYCLES (COMPARE_CYCLES),
  .REWRITE_CYCLES (REWRITE_CYCLES)
) chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_ext_busy(i_ext_busy),
  .o_so_oe(o_so_oe), .o_op_start(o_op_start), .o_op_kind(o_op_kind),
  .o_op_buf(o_op_buf), .o_page_index_bits(o_page_index_bits), .o_ready(o_ready)
);
`default_nettype wire

// ===== sim/spi_host_model.sv
// Purpose: Serial host driving the command pins of the flash core
// Assumes: Mode 0, link clock period 800 ns, MSB first
// Notes:   Link clock stands low between frames
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // Serial pins
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  input  wire logic i_so
);
  // Idle pins at start
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end
  // One frame: n_in bits shifted out, then n_out bits taken at each rise
  // Page refreshes are issued as rewrite frames
  task automatic xfer(input logic [31:0] tx, input int n_in, input int n_out,
                      output logic [31:0] rx);
    rx = 32'h0;
    #37 o_cs_n = 1'b0; // Held low for the whole frame
    for (int i = 0; i < n_in + n_out; i++) begin
      o_si = (i < n_in) ? tx[31 - i] : ~o_si;
      #400 o_sck = 1'b1;
      if (i >= n_in) rx = {rx[30:0], i_so};
      #400 o_sck = 1'b0;
    end
    #400 o_cs_n = 1'b1;
    o_si = ~o_si; // Released line shows no stale value
    #1000;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ===== sim/page_ops_core_bench.sv
// Purpose: Self-checking bench for page_ops_core
// Assumes: Shortened operation times; host model on the serial pins
// Notes:   Model keeps expected operations in a queue and the compare bit
`timescale 1ns/100ps
`default_nettype none
module page_ops_core_bench;
  localparam logic [7:0] OPS [6] = '{flash_ops_pkg::OPC_COPY_ONE,
    flash_ops_pkg::OPC_COPY_TWO, flash_ops_pkg::OPC_CMP_ONE,
    flash_ops_pkg::OPC_CMP_TWO, flash_ops_pkg::OPC_RW_ONE, flash_ops_pkg::OPC_RW_TWO};
  logic        i_clk, i_rst, cs_n, sck, si, so, so_oe, busy, prot, p512;
  logic        flt, lock, ps2, ps1, es, mis, start, buf_sel, rdy, cmp_bit;
  logic [1:0]  kind;
  logic [11:0] page;
  logic [31:0] rx;
  logic [31:0] seed = 32'hd09b422a;
  logic [14:0] exp_q[$];
  int          err_count, samples_checked, cyc;
  page_ops_core #(.COPY_CYCLES(20), .COMPARE_CYCLES(20), .REWRITE_CYCLES(200)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so),
    .o_so_oe(so_oe), .i_ext_busy(busy), .i_protect_on(prot), .i_page_512(p512),
    .i_program_erase_fault(flt), .i_lockdown_allowed_flag(lock),
    .i_buf_two_program_paused(ps2), .i_buf_one_program_paused(ps1),
    .i_erase_paused_flag(es), .i_cmp_mismatch(mis), .o_op_start(start),
    .o_op_kind(kind), .o_op_buf(buf_sel), .o_page_index_bits(page), .o_ready(rdy));
  spi_host_model host_u (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));
  // Clock and hang limit
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk_st(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t status got %h exp %h", $time, got, exp);
    end
  endtask : chk_st
  task automatic chk_op(input logic [14:0] got, input logic [14:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t op got %h exp %h", $time, got, exp);
    end
  endtask : chk_op
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // Every start pulse must match the oldest expected operation
  always @(posedge i_clk)
    if (start === 1'b1) chk_op({kind, buf_sel, page},
      exp_q.size() > 0 ? exp_q.pop_front() : 15'h7fff);
  task automatic rand_in(input logic pm);
    @(posedge i_clk);
    #1 {prot, flt, lock, ps2, ps1, es, mis} = 7'(rnd());
    p512 = pm;
  endtask : rand_in
  task automatic op(input logic [7:0] opc, input logic [1:0] k, input logic b,
                    input logic pm);
    logic [23:0] a;
    logic [11:0] pg;
    logic        ok;
    rand_in(pm);
    a  = 24'(rnd());
    pg = p512 ? a[20:9] : a[21:10];
    ok = !busy && (k == 2'h1 || !(b ? ps2 : ps1));
    if (ok) exp_q.push_back({(k == 2'h1) ? 2'h1 : 2'h0, b, pg});
    if (ok && k == 2'h2) exp_q.push_back({2'h2, b, pg});
    host_u.xfer({opc, a}, 32, 0, rx);
    for (int n = 0; n < 400 && rdy !== 1'b1; n++) @(posedge i_clk);
    if (ok && k == 2'h1) cmp_bit = mis;
  endtask : op
  task automatic rd_st();
    logic [15:0] e;
    rand_in(p512);
    e = {!busy, cmp_bit, flash_ops_pkg::SIZE_CODE_DEFAULT, prot, p512,
         !busy, 1'b0, flt, 1'b0, lock, ps2, ps1, es};
    host_u.xfer({flash_ops_pkg::OPC_STATUS, 24'h0}, 8, 32, rx);
    chk_st(rx, {e, e});
  endtask : rd_st
  // Main sequence
  initial begin
    i_rst = 1'b1;
    busy = 1'b0;
    cmp_bit = 1'b0;
    {prot, p512, flt, lock, ps2, ps1, es, mis} = 8'h0;
    repeat (6) @(posedge i_clk);
    #1 i_rst = 1'b0;
    chk_st({28'h0, so, so_oe, start, rdy}, 32'h1);
    rd_st();
    for (int i = 0; i < 12; i++) begin
      op(OPS[i % 6], 2'((i % 6) / 2), 1'(i % 2), 1'(i / 6));
      rd_st();
    end
    @(posedge i_clk);
    #1 busy = 1'b1;
    rd_st();
    op(OPS[4], 2'h2, 1'b0, 1'b0);
    @(posedge i_clk);
    #1 busy = 1'b0;
    host_u.xfer({OPS[0], 24'h0}, 24, 0, rx);
    host_u.xfer({flash_ops_pkg::OPC_STATUS, 24'h0}, 8, 3, rx);
    chk_st({31'h0, so_oe}, 32'h0);
    rd_st();
    chk_st(32'(exp_q.size()), 32'h0);
    print_verdict();
  end
endmodule : page_ops_core_bench
`default_nettype wire
